// [verilog/sem_port_ctrl.sv]
// host-side controller that drives one port of the semaphore flags
`timescale 1ns/1ps
`include "sem_ctrl_regs.svh"
// How it works
// - flags are active low; write zero requests, write one releases
// - access with flag select low, using address, enable and read/write
// - select or output enable must go high between repeated reads
// - a request writes zero first, then reads back to confirm
// - after a failure keep reading or write one to withdraw
// - chip enable stays high while flag select is low
// - at start software writes one to every flag from both ports
module sem_port_ctrl
   import sem_ctrl_pkg::*;
#(
   parameter int ACCESS_CYC = `SEM_ACCESS_CYC,
   parameter int GAP_CYC = `SEM_GAP_CYC
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // command side
   input wire logic cmd_valid,
   input wire sem_op_t cmd_op,
   input wire logic [`SEM_IDX_W-1:0] cmd_flag,
   output logic cmd_ready,
   output logic done,
   output logic granted,
   output logic fail,
   // device port pins
   output logic flag_space_select_n,
   output logic chip_enable_n,
   output logic rw_n,
   output logic output_enable_n,
   output logic [`SEM_IDX_W-1:0] flag_index,
   input wire logic [`SEM_DATA_W-1:0] data_in,
   output logic data0_out,
   output logic data0_oe
);
   // the read count runs to ACCESS_CYC + 1 in eight bits; the gap must span two samples
   if (ACCESS_CYC < 1 || ACCESS_CYC > 254 || GAP_CYC < 2 || GAP_CYC > 255) begin : bad_counts
      $error("sem_port_ctrl: cycle counts out of range");
   end

   sem_state_t state;
   sem_op_t op;
   logic [7:0] cnt;
   logic [`SEM_IDX_W-1:0] init_idx;
   logic [`SEM_DATA_W-1:0] data_sync;
   logic last_access;

   sem_pin_sync #(.WIDTH(`SEM_DATA_W)) u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .pin_in(data_in),
      .pin_sync(data_sync)
   );

   assign cmd_ready = (state == st_idle);
   assign last_access = (cnt == 8'(ACCESS_CYC - 1));

   ////////////////////////////////////////////////////////////////////
   // sequencer: request writes then reads back, test only reads, release and init only write; gap after each write
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= st_idle;
         op <= op_test;
         cnt <= 8'h00;
         init_idx <= 3'h0;
      end else begin
         unique case (state)
            st_idle: begin
               cnt <= 8'h00;
               if (cmd_valid) begin
                  op <= cmd_op;
                  init_idx <= (cmd_op == op_init) ? 3'h0 : cmd_flag;
                  state <= (cmd_op == op_test) ? st_read : st_write;
               end
            end
            st_write: begin
               cnt <= cnt + 8'h01;
               if (last_access) begin
                  cnt <= 8'h00;
                  state <= st_gap;
               end
            end
            st_read: begin
               cnt <= cnt + 8'h01;
               if (cnt == 8'(ACCESS_CYC + 1)) begin
                  cnt <= 8'h00;
                  state <= st_done;
               end
            end
            st_gap: begin
               cnt <= cnt + 8'h01;
               if (cnt == 8'(GAP_CYC - 1)) begin
                  cnt <= 8'h00;
                  if (op == op_request) begin
                     state <= st_read;
                  end else if (op == op_init && init_idx != 3'h7) begin
                     init_idx <= init_idx + 3'h1;
                     state <= st_write;
                  end else begin
                     state <= st_done;
                  end
               end
            end
            st_done: state <= st_idle;
            default: state <= st_idle;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pin drive
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         flag_space_select_n <= 1'h1;
         chip_enable_n <= 1'h1;
         rw_n <= 1'h1;
         output_enable_n <= 1'h1;
         flag_index <= 3'h0;
         data0_out <= 1'h1;
         data0_oe <= 1'h0;
      end else begin
         chip_enable_n <= 1'h1;
         flag_index <= init_idx;
         flag_space_select_n <= !(state == st_write || state == st_read);
         rw_n <= !(state == st_write);
         output_enable_n <= !(state == st_read);
         data0_oe <= (state == st_write);
         data0_out <= (op == op_request) ? `SEM_FLAG_TAKEN : `SEM_FLAG_FREE;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // result: flag read low means this port owns the token
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         done <= 1'h0;
         granted <= 1'h0;
         fail <= 1'h0;
      end else begin
         done <= 1'h0;
         if (state == st_read && cnt == 8'(ACCESS_CYC + 1)) begin
            done <= 1'h1;
            granted <= (data_sync == '0);
            fail <= (data_sync != '0);
         end else if (state == st_gap && cnt == 8'(GAP_CYC - 1) && op != op_request
                      && !(op == op_init && init_idx != 3'h7)) begin
            done <= 1'h1;
            granted <= 1'h0;
            fail <= 1'h0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // checks
   chip_off_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !flag_space_select_n |-> chip_enable_n)
      else $error("chip enable active during flag access");
   write_data_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      data0_oe |-> (!rw_n && !flag_space_select_n))
      else $error("data driven outside a flag write");
   request_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (data0_oe && op == op_request) |-> data0_out == 1'h0)
      else $error("request did not write zero");
   read_gap_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(flag_space_select_n) |=> flag_space_select_n)
      else $error("select not released between accesses");
   write_first_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (cmd_ready && cmd_valid && cmd_op == op_request) |=> state == st_write)
      else $error("request did not start with a write");
   done_verdict_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      done |-> !(granted && fail))
      else $error("grant and fail together");
   oe_read_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      !output_enable_n |-> (rw_n && !flag_space_select_n && !data0_oe))
      else $error("output enable outside a flag read");
   release_one_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (data0_oe && op != op_request) |-> data0_out == 1'h1)
      else $error("release did not write one");
   index_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!flag_space_select_n && !$past(flag_space_select_n)) |-> $stable(flag_index))
      else $error("flag index moved during an access");
   write_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (data0_oe && $past(data0_oe)) |-> $stable(data0_out))
      else $error("written data bit moved during a write");
   read_follows_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      ($fell(data0_oe) && op == op_request) |-> ##GAP_CYC !output_enable_n)
      else $error("request write not followed by a read");
   test_no_write_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (!cmd_ready && op == op_test) |-> !data0_oe)
      else $error("test command wrote the flag");
   release_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      (done && op != op_request && op != op_test) |-> (!granted && !fail))
      else $error("release reported a verdict");
   read_release_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
      $rose(output_enable_n) |-> flag_space_select_n)
      else $error("select held low after a read");
   request_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
      done && granted);
   fail_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
      done && fail);
   init_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
      state == st_write && op == op_init && init_idx == 3'h7);
   test_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
      done && op == op_test && granted);
   withdraw_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
      done && op == op_release && $past(fail));
endmodule

// [verilog/sem_ctrl_regs.svh]
// timing counts and pin constants for the semaphore port controller
`ifndef SEM_CTRL_REGS_SVH
`define SEM_CTRL_REGS_SVH
`define SEM_NUM_FLAGS 8
`define SEM_IDX_W 3
`define SEM_DATA_W 16
`define SEM_ACCESS_NS 20
`define SEM_CLK_NS 4
`define SEM_ACCESS_CYC ((`SEM_ACCESS_NS + `SEM_CLK_NS - 1) / `SEM_CLK_NS)
`define SEM_GAP_CYC 2
`define SEM_FLAG_FREE 1'h1
`define SEM_FLAG_TAKEN 1'h0
`endif

// [verilog/sem_ctrl_pkg.sv]
// types for the semaphore port controller
package sem_ctrl_pkg;
   typedef enum logic [1:0] {
      op_request = 2'b00,
      op_release = 2'b01,
      op_test = 2'b10,
      op_init = 2'b11
   } sem_op_t;
   typedef enum logic [2:0] {
      st_idle = 3'b000,
      st_write = 3'b001,
      st_read = 3'b010,
      st_gap = 3'b011,
      st_done = 3'b100
   } sem_state_t;
endpackage

// [verilog/sem_pin_sync.sv]
// two flip-flop synchroniser for the data pins read back from the port
`timescale 1ns/1ps
module sem_pin_sync #(
   parameter int WIDTH = 16
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // pins
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_sync
);
   logic [WIDTH-1:0] stage1;
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= '0;
         pin_sync <= '0;
      end else begin
         stage1 <= pin_in;
         pin_sync <= stage1;
      end
   end
endmodule

// [testbench/sem_flag_model.sv]
// behavioural two-port semaphore flag device
`timescale 1ns/1ps
module sem_flag_model (
   // sampling clock
   input wire logic ref_clk,
   // port pins, bit 0 left, bit 1 right
   input wire logic [1:0] sel_n,
   input wire logic [1:0] ce_n,
   input wire logic [1:0] rw_n,
   input wire logic [1:0] oe_n,
   input wire logic [1:0][2:0] idx,
   input wire logic [1:0] d0,
   // read data
   output logic [15:0] q0,
   output logic [15:0] q1
);
   // no power-up state: left holds every flag, right waits on each
   int own [8] = '{default: 0};
   logic [7:0] req [2] = '{8'h00, 8'h00};
   logic [1:0] lat = 2'h3;
   logic [1:0] was = 2'h0;
   always @(posedge ref_clk) begin
      for (int p = 0; p < 2; p++) begin
         if (!sel_n[p] && ce_n[p] && !rw_n[p]) begin
            req[p][idx[p]] = d0[p];
            if (!d0[p] && own[idx[p]] < 0) own[idx[p]] = p;
            if (d0[p] && own[idx[p]] == p) own[idx[p]] = req[1-p][idx[p]] ? -1 : 1 - p;
         end
         if (!sel_n[p] && !oe_n[p] && !was[p]) lat[p] = own[idx[p]] != p;
         was[p] = !sel_n[p] && !oe_n[p];
      end
   end
   // a released bus shows the inverse of the last value
   assign q0 = {16{lat[0] ^ (sel_n[0] | oe_n[0])}};
   assign q1 = {16{lat[1] ^ (sel_n[1] | oe_n[1])}};
endmodule

// [testbench/testbench.sv]
// self-checking bench for the semaphore port controller
`timescale 1ns/1ps
module testbench;
   import sem_ctrl_pkg::*;
   logic ref_clk = 0, rst_b = 0, cmd_valid = 0;
   sem_op_t cmd_op = op_test;
   logic [2:0] cmd_flag = 3'h0, flag_index, r_idx = 3'h0;
   logic cmd_ready, done, granted, fail, data0_out, data0_oe;
   logic flag_space_select_n, chip_enable_n, rw_n, output_enable_n;
   logic r_sel_n = 1, r_rw_n = 1, r_oe_n = 1, r_d0 = 1;
   logic [15:0] data_in, q1;
   int miscompares = 0, checks_done = 0, own [8] = '{default: 0}, f, base;
   logic [7:0] req [2] = '{8'h00, 8'h00};
   sem_port_ctrl u_dut (.ref_clk, .rst_b, .cmd_valid, .cmd_op, .cmd_flag, .cmd_ready, .done,
      .granted, .fail, .flag_space_select_n, .chip_enable_n, .rw_n, .output_enable_n,
      .flag_index, .data_in, .data0_out, .data0_oe);
   sem_flag_model u_dev (.ref_clk, .sel_n({r_sel_n, flag_space_select_n}),
      .ce_n({1'b1, chip_enable_n}), .rw_n({r_rw_n, rw_n}), .oe_n({r_oe_n, output_enable_n}),
      .idx({r_idx, flag_index}), .d0({r_d0, data0_out ^ !data0_oe}), .q0(data_in), .q1(q1));
   always #2 ref_clk = ~ref_clk;
   ////////////////////////////////////////////////////////////
   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic mwr(int p, int i, bit v);
      req[p][i] = v;
      if (!v && own[i] < 0) own[i] = p;
      if (v && own[i] == p) own[i] = req[1-p][i] ? -1 : 1 - p;
   endtask
   task automatic cmd(sem_op_t op, int i);
      bit rd;
      rd = (op == op_request || op == op_test);
      @(posedge ref_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_flag <= 3'(i);
      #1 chk("ready", 16'h1, {15'h0, cmd_ready});
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      #1 chk("busy", 16'h0, {15'h0, cmd_ready});
      for (int n = 0; n < 300 && done !== 1'b1; n++) @(posedge ref_clk) #1;
      chk("done", 16'h1, {15'h0, done});
      if (op == op_init) for (int k = 0; k < 8; k++) mwr(0, k, 1);
      if (op == op_request || op == op_release) mwr(0, i, op == op_release);
      chk("granted", {15'h0, rd && own[i] == 0}, {15'h0, granted});
      chk("fail", {15'h0, rd && own[i] != 0}, {15'h0, fail});
   endtask
   task automatic rport(int i, bit wr, bit v);
      @(posedge ref_clk);
      r_sel_n <= 1'b0;
      r_rw_n <= !wr;
      r_oe_n <= wr;
      r_idx <= 3'(i);
      r_d0 <= v;
      repeat (3) @(posedge ref_clk);
      if (wr) mwr(1, i, v);
      else chk("right flag", {16{own[i] != 1}}, q1);
      r_sel_n <= 1'b1;
      r_rw_n <= 1'b1;
      r_oe_n <= 1'b1;
      r_d0 <= ~v;
   endtask
   task automatic give_verdict();
      if (miscompares == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #100000;
      miscompares++;
      give_verdict();
   end
   initial begin
      base = $urandom(94557) % 8;
      repeat (4) @(posedge ref_clk);
      rst_b <= 1'b1;
      cmd(op_init, 0);
      for (int i = 0; i < 8; i++) rport(i, 1, 1);
      for (int k = 0; k < 8; k++) begin
         f = (k + base) % 8;
         cmd(op_test, f);
         rport(f, 1, 0);
         cmd(op_request, f);
         rport(f, 1, 1);
         cmd(op_test, f);
         rport(f, 0, 0);
         cmd(op_release, f);
         rport(f, 0, 0);
         fork
            cmd(op_request, f);
            rport(f, 1, 0);
         join
         cmd(op_release, f);
         rport(f, 1, 1);
         cmd(op_test, f);
      end
      give_verdict();
   end
endmodule
